// ===== sbc_pkg.sv
/*
  Constants, field positions, timing counts and state types for the
  serial-bus control and status block.
  Assumes a 10 MHz device clock and an 8-bit register window.
*/
package sbc_pkg;

  // Register placement and reset value.
  localparam logic [7:0] CSR_OFFSET = 8'h47;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // Field positions inside the control and status register.
  localparam int BIT_ADDR_MODE = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_SW_BUSY = 5;
  localparam int BIT_LOAD_BUSY = 4;
  localparam int BIT_PRESENT = 3;
  localparam int BIT_FAST_CLK = 2;
  localparam int BIT_SW_ERR = 1;
  localparam int BIT_LOAD_ERR = 0;

  // Serial-bus clock rates; one bit takes four quarter periods.
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_NORMAL_HZ = 60_000;
  localparam int SCL_TEST_HZ = 4_000_000;
  localparam int QTR_NORMAL_RAW = CLK_HZ / (4 * SCL_NORMAL_HZ);
  localparam int QTR_TEST_RAW = CLK_HZ / (4 * SCL_TEST_HZ);
  // A quarter must outlast the two output flops and the input filter.
  localparam int QTR_MIN = 3;
  localparam logic [7:0] QTR_NORMAL = 8'((QTR_NORMAL_RAW < QTR_MIN) ? QTR_MIN : QTR_NORMAL_RAW);
  localparam logic [7:0] QTR_TEST = 8'((QTR_TEST_RAW < QTR_MIN) ? QTR_MIN : QTR_TEST_RAW);

  // Loader settings.
  localparam logic [6:0] EEPROM_SLAVE = 7'h50;
  localparam logic [7:0] LOAD_START = 8'h00;
  localparam logic [7:0] LOAD_BYTES = 8'h10;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Reset values of the synchronised inputs: clock, data, platform reset.
  localparam logic [2:0] SYNC_RESET = 3'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_TX = 5'b00100,
    ST_RX = 5'b01000,
    ST_STOP = 5'b10000
  } sbc_state_e;

  typedef enum logic [2:0] {
    JOB_DETECT = 3'b001,
    JOB_LOAD = 3'b010,
    JOB_SW = 3'b100
  } sbc_job_e;

  typedef enum logic [2:0] {
    KIND_ADDR = 3'b001,
    KIND_WORD = 3'b010,
    KIND_DATA = 3'b100
  } sbc_kind_e;

endpackage

// ===== sbc_sync3.sv
/*
  Three-stage input synchroniser with agreement filter, one bit per lane.
  Assumes inputs are asynchronous to clk_i; output moves only when the
  second and third stages agree.
*/
`timescale 1ns/10ps
`default_nettype none

module sbc_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous in, filtered out.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  wire logic [WIDTH-1:0] nxt_out = (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
      out_ff <= RESET_VAL;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_o = out_ff;

endmodule

`default_nettype wire

// ===== sbc_ctrl.sv
/*
  Serial-bus control and status register with its two-wire master:
  EEPROM detection and default download, and software single-byte cycles.
  Assumes reset_i is the fundamental reset, the PCI header copy is
  selected by its own strobes, and pins are open drain resolved outside.
*/
`timescale 1ns/10ps
`default_nettype none

module sbc_ctrl (
  // Clock and fundamental reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Platform reset pin, active low.
  input wire logic platform_reset_n_i,
  // Memory-window register port.
  input wire logic [7:0] mw_addr_i,
  input wire logic mw_wr_i,
  input wire logic mw_rd_i,
  input wire logic [7:0] mw_wdata_i,
  output logic [7:0] mw_rdata_o,
  // PCI header copy of the register.
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // Software cycle, from the slave, word and data registers.
  input wire logic sw_launch_i,
  input wire logic [7:0] sw_slave_addr_i,
  input wire logic [7:0] sw_word_addr_i,
  input wire logic [7:0] sw_wr_data_i,
  output logic [7:0] sw_rd_data_o,
  // Download stream toward the register defaults.
  output logic load_wr_o,
  output logic [7:0] load_index_o,
  output logic [7:0] load_data_o,
  // GPIO side of the shared pins.
  input wire logic gpio_clk_out_i,
  input wire logic gpio_clk_oe_n_i,
  input wire logic gpio_data_out_i,
  input wire logic gpio_data_oe_n_i,
  output logic gpio_clk_in_o,
  output logic gpio_data_in_o,
  // Shared pins, open drain style.
  input wire logic shared_pin_clock_i,
  output logic shared_pin_clock_o,
  output logic shared_pin_clock_oe_n_o,
  input wire logic shared_pin_data_i,
  output logic shared_pin_data_o,
  output logic shared_pin_data_oe_n_o
);

  sbc_pkg::sbc_state_e state_ff, nxt_state;
  sbc_pkg::sbc_job_e job_ff, nxt_job;
  sbc_pkg::sbc_kind_e kind_ff, nxt_kind;
  logic [1:0] q_ff, nxt_q;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] div_ff;
  logic [7:0] slave_ff, nxt_slave;
  logic [7:0] word_ff, nxt_word;
  logic [7:0] wdata_ff, nxt_wdata;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic [7:0] load_idx_ff, nxt_load_idx;
  logic [7:0] load_data_ff, nxt_load_data;
  logic load_wr_ff, nxt_load_wr;
  logic word_sent_ff, nxt_word_sent;
  logic data_sent_ff, nxt_data_sent;
  logic rd_phase_ff, nxt_rd_phase;
  logic addr_rd_ff, nxt_addr_rd;
  logic arm_ff, nxt_arm;
  logic samp_ff;
  logic scl_ff, sda_ff;
  logic addr_mode_ff, present_ff, fast_ff, sw_err_ff, load_err_ff;
  logic set_present, set_sw_err, set_load_err;
  logic [7:0] mw_rdata_ff, cfg_rdata_ff;
  logic pclk_ff, pclk_oe_n_ff, pdat_ff, pdat_oe_n_ff;
  logic scl_want, sda_want;
  logic [2:0] sync_q;

  sbc_sync3 #(.WIDTH(3), .RESET_VAL(sbc_pkg::SYNC_RESET)) u_sync (
    .clk_i(sys_clk_i),
    .rst_i(reset_i),
    .async_i({platform_reset_n_i, shared_pin_data_i, shared_pin_clock_i}),
    .sync_o(sync_q)
  );

  wire logic prst_high = sync_q[2];
  wire logic sda_q = sync_q[1];
  wire logic is_idle = (state_ff == sbc_pkg::ST_IDLE);
  wire logic is_sw = (job_ff == sbc_pkg::JOB_SW);
  wire logic is_load = (job_ff == sbc_pkg::JOB_LOAD);
  wire logic [7:0] qtr = fast_ff ? sbc_pkg::QTR_TEST : sbc_pkg::QTR_NORMAL;
  wire logic tick = (div_ff == 8'h00);
  wire logic step = tick && !is_idle;
  wire logic end_slot = step && (q_ff == 2'h3);
  wire logic ack_slot = (bit_ff == sbc_pkg::ACK_SLOT);
  wire logic need_word = is_load || (is_sw && !addr_mode_ff);
  wire logic want_read = is_load || (is_sw && slave_ff[0]);
  wire logic rd_bit = rd_phase_ff || (is_sw && slave_ff[0] && !need_word);
  wire logic [6:0] dev7 = is_sw ? slave_ff[7:1] : sbc_pkg::EEPROM_SLAVE;
  wire logic [7:0] word_src = is_sw ? word_ff : sbc_pkg::LOAD_START;
  wire logic last_load = (cnt_ff == 8'(sbc_pkg::LOAD_BYTES - 8'h01));
  wire logic rx_nack = is_sw || last_load;
  wire logic sw_busy = is_sw && !is_idle;
  wire logic load_busy = !is_sw && !is_idle;
  wire logic [7:0] csr_view = {addr_mode_ff, 1'b0, sw_busy, load_busy, present_ff, fast_ff,
                              sw_err_ff, load_err_ff};
  wire logic mw_hit = (mw_addr_i == sbc_pkg::CSR_OFFSET);
  wire logic wr_any = (mw_wr_i && mw_hit) || cfg_wr_i;
  wire logic [7:0] wd = (mw_wr_i && mw_hit) ? mw_wdata_i : cfg_wdata_i;
  // shared pins follow the bus while present or probing.
  wire logic bus_on = present_ff || !is_idle;

  always_comb begin
    scl_want = 1'b1;
    sda_want = 1'b1;
    unique case (state_ff)
      sbc_pkg::ST_START: begin
        scl_want = (q_ff == 2'h1) || (q_ff == 2'h2);
        sda_want = (q_ff < 2'h2);
      end
      sbc_pkg::ST_TX: begin
        scl_want = q_ff[1];
        sda_want = ack_slot ? 1'b1 : shift_ff[7];
      end
      sbc_pkg::ST_RX: begin
        scl_want = q_ff[1];
        sda_want = ack_slot ? rx_nack : 1'b1;
      end
      sbc_pkg::ST_STOP: begin
        scl_want = (q_ff != 2'h0);
        sda_want = q_ff[1];
      end
      default: begin
        scl_want = 1'b1;
        sda_want = 1'b1;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_job = job_ff;
    nxt_kind = kind_ff;
    nxt_q = step ? 2'(q_ff + 2'h1) : q_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_cnt = cnt_ff;
    nxt_slave = slave_ff;
    nxt_word = word_ff;
    nxt_wdata = wdata_ff;
    nxt_rd_data = rd_data_ff;
    nxt_load_idx = load_idx_ff;
    nxt_load_data = load_data_ff;
    nxt_load_wr = 1'b0;
    nxt_word_sent = word_sent_ff;
    nxt_data_sent = data_sent_ff;
    nxt_rd_phase = rd_phase_ff;
    nxt_addr_rd = addr_rd_ff;
    // re-arm detection while platform reset is held.
    nxt_arm = arm_ff || !prst_high;
    set_present = 1'b0;
    set_sw_err = 1'b0;
    set_load_err = 1'b0;
    unique case (state_ff)
      sbc_pkg::ST_IDLE: begin
        nxt_q = 2'h0;
        nxt_word_sent = 1'b0;
        nxt_data_sent = 1'b0;
        nxt_rd_phase = 1'b0;
        nxt_cnt = 8'h00;
        if (arm_ff && prst_high) begin
          nxt_arm = 1'b0;
          nxt_job = sbc_pkg::JOB_DETECT;
          nxt_state = sbc_pkg::ST_START;
        end else if (sw_launch_i) begin
          if (present_ff) begin
            nxt_job = sbc_pkg::JOB_SW;
            nxt_slave = sw_slave_addr_i;
            nxt_word = sw_word_addr_i;
            nxt_wdata = sw_wr_data_i;
            nxt_state = sbc_pkg::ST_START;
          end else begin
            set_sw_err = 1'b1;
          end
        end
      end
      sbc_pkg::ST_START: begin
        if (end_slot) begin
          nxt_state = sbc_pkg::ST_TX;
          nxt_kind = sbc_pkg::KIND_ADDR;
          nxt_shift = {dev7, rd_bit};
          nxt_addr_rd = rd_bit;
          nxt_bit = 4'h0;
        end
      end
      sbc_pkg::ST_TX: begin
        if (end_slot && !ack_slot) begin
          nxt_shift = {shift_ff[6:0], samp_ff};
          nxt_bit = 4'(bit_ff + 4'h1);
        end else if (end_slot) begin
          nxt_bit = 4'h0;
          if (samp_ff) begin
            nxt_state = sbc_pkg::ST_STOP;
            set_sw_err = is_sw;
            set_load_err = is_load;
          end else if (job_ff == sbc_pkg::JOB_DETECT) begin
            set_present = 1'b1;
            nxt_state = sbc_pkg::ST_STOP;
          end else if (kind_ff == sbc_pkg::KIND_ADDR && addr_rd_ff) begin
            nxt_state = sbc_pkg::ST_RX;
          end else if (need_word && !word_sent_ff) begin
            nxt_kind = sbc_pkg::KIND_WORD;
            nxt_shift = word_src;
            nxt_word_sent = 1'b1;
          end else if (want_read) begin
            nxt_state = sbc_pkg::ST_START;
            nxt_rd_phase = 1'b1;
          end else if (!data_sent_ff) begin
            nxt_kind = sbc_pkg::KIND_DATA;
            nxt_shift = wdata_ff;
            nxt_data_sent = 1'b1;
          end else begin
            nxt_state = sbc_pkg::ST_STOP;
          end
        end
      end
      sbc_pkg::ST_RX: begin
        if (end_slot && !ack_slot) begin
          nxt_shift = {shift_ff[6:0], samp_ff};
          nxt_bit = 4'(bit_ff + 4'h1);
        end else if (end_slot) begin
          nxt_bit = 4'h0;
          if (is_sw) begin
            nxt_rd_data = shift_ff;
            nxt_state = sbc_pkg::ST_STOP;
          end else begin
            nxt_load_wr = 1'b1;
            nxt_load_idx = cnt_ff;
            nxt_load_data = shift_ff;
            nxt_cnt = 8'(cnt_ff + 8'h01);
            if (last_load) begin
              nxt_state = sbc_pkg::ST_STOP;
            end
          end
        end
      end
      sbc_pkg::ST_STOP: begin
        if (end_slot) begin
          if (job_ff == sbc_pkg::JOB_DETECT && present_ff) begin
            nxt_job = sbc_pkg::JOB_LOAD;
            nxt_state = sbc_pkg::ST_START;
            nxt_word_sent = 1'b0;
            nxt_rd_phase = 1'b0;
            nxt_cnt = 8'h00;
          end else begin
            nxt_state = sbc_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = sbc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= sbc_pkg::ST_IDLE;
      job_ff <= sbc_pkg::JOB_DETECT;
      kind_ff <= sbc_pkg::KIND_ADDR;
      q_ff <= 2'h0;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      cnt_ff <= 8'h00;
      word_sent_ff <= 1'b0;
      data_sent_ff <= 1'b0;
      rd_phase_ff <= 1'b0;
      addr_rd_ff <= 1'b0;
      arm_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      job_ff <= nxt_job;
      kind_ff <= nxt_kind;
      q_ff <= nxt_q;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      cnt_ff <= nxt_cnt;
      word_sent_ff <= nxt_word_sent;
      data_sent_ff <= nxt_data_sent;
      rd_phase_ff <= nxt_rd_phase;
      addr_rd_ff <= nxt_addr_rd;
      arm_ff <= nxt_arm;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      slave_ff <= 8'h00;
      word_ff <= 8'h00;
      wdata_ff <= 8'h00;
      rd_data_ff <= 8'h00;
      load_idx_ff <= 8'h00;
      load_data_ff <= 8'h00;
      load_wr_ff <= 1'b0;
      div_ff <= 8'h00;
      samp_ff <= 1'b1;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      slave_ff <= nxt_slave;
      word_ff <= nxt_word;
      wdata_ff <= nxt_wdata;
      rd_data_ff <= nxt_rd_data;
      load_idx_ff <= nxt_load_idx;
      load_data_ff <= nxt_load_data;
      load_wr_ff <= nxt_load_wr;
      div_ff <= tick ? 8'(qtr - 8'h01) : 8'(div_ff - 8'h01);
      samp_ff <= (step && q_ff == 2'h2) ? sda_q : samp_ff;
      scl_ff <= scl_want;
      sda_ff <= sda_want;
    end
  end

  // register reset and storage; errors held until cleared.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_mode_ff <= sbc_pkg::CSR_RESET[sbc_pkg::BIT_ADDR_MODE];
      present_ff <= sbc_pkg::CSR_RESET[sbc_pkg::BIT_PRESENT];
      fast_ff <= sbc_pkg::CSR_RESET[sbc_pkg::BIT_FAST_CLK];
      sw_err_ff <= sbc_pkg::CSR_RESET[sbc_pkg::BIT_SW_ERR];
      load_err_ff <= sbc_pkg::CSR_RESET[sbc_pkg::BIT_LOAD_ERR];
      mw_rdata_ff <= 8'h00;
      cfg_rdata_ff <= 8'h00;
    end else begin
      addr_mode_ff <= wr_any ? wd[sbc_pkg::BIT_ADDR_MODE] : addr_mode_ff;
      present_ff <= set_present || (wr_any ? wd[sbc_pkg::BIT_PRESENT] : present_ff);
      fast_ff <= wr_any ? wd[sbc_pkg::BIT_FAST_CLK] : fast_ff;
      sw_err_ff <= set_sw_err || (sw_err_ff && !(wr_any && wd[sbc_pkg::BIT_SW_ERR]));
      load_err_ff <= set_load_err || (load_err_ff && !(wr_any && wd[sbc_pkg::BIT_LOAD_ERR]));
      mw_rdata_ff <= (mw_rd_i && mw_hit) ? csr_view : 8'h00;
      cfg_rdata_ff <= cfg_rd_i ? csr_view : 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pclk_ff <= 1'b0;
      pclk_oe_n_ff <= 1'b1;
      pdat_ff <= 1'b0;
      pdat_oe_n_ff <= 1'b1;
    end else begin
      pclk_ff <= bus_on ? 1'b0 : gpio_clk_out_i;
      pclk_oe_n_ff <= bus_on ? scl_ff : gpio_clk_oe_n_i;
      pdat_ff <= bus_on ? 1'b0 : gpio_data_out_i;
      pdat_oe_n_ff <= bus_on ? sda_ff : gpio_data_oe_n_i;
    end
  end

  assign mw_rdata_o = mw_rdata_ff;
  assign cfg_rdata_o = cfg_rdata_ff;
  assign sw_rd_data_o = rd_data_ff;
  assign load_wr_o = load_wr_ff;
  assign load_index_o = load_idx_ff;
  assign load_data_o = load_data_ff;
  assign gpio_clk_in_o = sync_q[0];
  assign gpio_data_in_o = sync_q[1];
  assign shared_pin_clock_o = pclk_ff;
  assign shared_pin_clock_oe_n_o = pclk_oe_n_ff;
  assign shared_pin_data_o = pdat_ff;
  assign shared_pin_data_oe_n_o = pdat_oe_n_ff;

endmodule

`default_nettype wire

// ===== sbc_eeprom_model.sv
/*
  Behavioural two-wire EEPROM slave for the serial-bus bench.
  Assumes the bench resolves open-drain clock and data levels for it.
*/
`timescale 1ns/10ps
`default_nettype none
module sbc_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // Resolved bus levels.
  input wire logic scl_i,
  input wire logic sda_i,
  // Fault knobs.
  input wire logic absent_i,
  input wire logic nack_word_i,
  // Data pull, high pulls the line low.
  output logic sda_pull_o = 1'h0
);
  logic [7:0] mem [0:255];
  logic [7:0] ptr = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic active = 1'h0;
  logic rd_mode = 1'h0;
  int bitc = 0;
  int nbyte = 0;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end
  // Data edges with the clock high frame a transfer.
  always @(negedge sda_i) begin
    #1;
    if (scl_i === 1'h1) begin
      active = 1'h1;
      rd_mode = 1'h0;
      bitc = 0;
      nbyte = 0;
    end
  end
  always @(posedge sda_i) begin
    #1;
    if (scl_i === 1'h1) begin
      active = 1'h0;
    end
  end
  always @(posedge scl_i) begin
    if (active) begin
      if (bitc < 8) sh = {sh[6:0], sda_i};
      else if (rd_mode && sda_i) active = 1'h0;
      bitc = bitc + 1;
    end
  end
  always @(negedge scl_i) begin
    if (active) begin
      sda_pull_o = 1'h0;
      if (bitc == 9) begin
        bitc = 0;
        if (rd_mode) begin
          tx = mem[ptr];
          ptr = ptr + 8'h01;
        end
      end else if (bitc == 8 && !rd_mode) begin
        if (nbyte == 0) begin
          sda_pull_o = (sh[7:1] == DEV_ADDR) && !absent_i;
          rd_mode = sh[0] && sda_pull_o;
        end else if (nbyte == 1) begin
          sda_pull_o = !nack_word_i;
          ptr = sh;
        end else begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
          sda_pull_o = 1'h1;
        end
        nbyte = nbyte + 1;
        if (!sda_pull_o) active = 1'h0;
      end
      if (rd_mode && bitc < 8) sda_pull_o = !tx[7 - bitc];
    end
  end
endmodule
`default_nettype wire

// ===== sbc_ctrl_assertions.sv
/*
  Port-level checks of the serial-bus control and status block.
  Assumes it is bound into sbc_ctrl and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module sbc_ctrl_chk (
  // Clock and resets.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic platform_reset_n_i,
  // Register views.
  input wire logic [7:0] mw_addr_i,
  input wire logic mw_wr_i,
  input wire logic mw_rd_i,
  input wire logic [7:0] mw_wdata_i,
  input wire logic [7:0] mw_rdata_o,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  // Download stream and pins.
  input wire logic load_wr_o,
  input wire logic [7:0] load_index_o,
  input wire logic gpio_clk_oe_n_i,
  input wire logic shared_pin_clock_o,
  input wire logic shared_pin_clock_oe_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic rd_ff;
  logic [1:0] clr_ff;
  logic [1:0] err_ff;
  logic [4:0] ld_cnt_ff;
  wire hit_rd = mw_rd_i && (mw_addr_i == sbc_pkg::CSR_OFFSET);
  wire hit_wr = mw_wr_i && (mw_addr_i == sbc_pkg::CSR_OFFSET);
  wire [1:0] clr = (hit_wr ? mw_wdata_i[1:0] : 2'h0) | (cfg_wr_i ? cfg_wdata_i[1:0] : 2'h0);
  wire [1:0] seen = rd_ff ? (mw_rdata_o[1:0] & ~clr_ff) : 2'h0;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_ff <= 1'h0;
      clr_ff <= 2'h0;
      err_ff <= 2'h0;
      ld_cnt_ff <= 5'h00;
    end else begin
      rd_ff <= hit_rd;
      clr_ff <= clr;
      err_ff <= (err_ff | seen) & ~clr;
      if (!platform_reset_n_i) ld_cnt_ff <= 5'h00;
      else if (load_wr_o) ld_cnt_ff <= ld_cnt_ff + 5'h01;
    end
  end
  a_rsvd_window: assert property (rd_ff |-> !mw_rdata_o[6])
    else $error("reserved bit read as one");
  a_rsvd_header: assert property (cfg_rd_i |=> !cfg_rdata_o[6])
    else $error("reserved bit read as one in header view");
  a_unmapped_zero: assert property ((mw_rd_i && !hit_rd) |=> mw_rdata_o == 8'h00)
    else $error("unmapped offset returned data");
  a_views_agree: assert property ((hit_rd && cfg_rd_i && !mw_wr_i && !cfg_wr_i)
    |=> mw_rdata_o == cfg_rdata_o) else $error("window and header views differ");
  a_errors_sticky: assert property (rd_ff |-> (mw_rdata_o[1:0] & err_ff) == err_ff)
    else $error("error flag dropped without a clear");
  a_load_order: assert property (load_wr_o |-> load_index_o == {3'h0, ld_cnt_ff})
    else $error("download index out of order");
  a_load_once: assert property (load_wr_o |-> ld_cnt_ff < 5'h10)
    else $error("download repeated without platform reset");
  a_load_pulse: assert property ($rose(load_wr_o) |=> !load_wr_o)
    else $error("download strobe longer than one cycle");
  a_bus_low_only: assert property (gpio_clk_oe_n_i [*3] ##0 !shared_pin_clock_oe_n_o
    |-> !shared_pin_clock_o) else $error("bus clock driven high");
  c_full_load: cover property (load_wr_o && load_index_o == 8'h0f);
  c_sw_error: cover property (rd_ff && mw_rdata_o[1]);
  c_sw_busy: cover property (rd_ff && mw_rdata_o[5]);
endmodule
bind sbc_ctrl sbc_ctrl_chk i_sbc_ctrl_chk (.*);
`default_nettype wire

// ===== tb_top.sv
/*
  Self-checking bench for the serial-bus control and status block.
  Assumes the EEPROM model answers at slave address 0x50.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic platform_reset_n_i = 1'h0;
  logic [7:0] mw_addr_i = 8'h00, mw_wdata_i = 8'h00, cfg_wdata_i = 8'h00;
  logic [7:0] sw_slave_addr_i = 8'h00, sw_word_addr_i = 8'h00, sw_wr_data_i = 8'h00;
  logic mw_wr_i = 1'h0, mw_rd_i = 1'h0, cfg_wr_i = 1'h0, cfg_rd_i = 1'h0, sw_launch_i = 1'h0;
  logic gpio_clk_out_i = 1'h1, gpio_clk_oe_n_i = 1'h1;
  logic gpio_data_out_i = 1'h1, gpio_data_oe_n_i = 1'h1;
  logic absent = 1'h0, nack_word = 1'h0;
  logic [7:0] mw_rdata_o, cfg_rdata_o, sw_rd_data_o, load_index_o, load_data_o;
  logic load_wr_o, gpio_clk_in_o, gpio_data_in_o, sda_pull;
  logic shared_pin_clock_o, shared_pin_clock_oe_n_o, shared_pin_data_o, shared_pin_data_oe_n_o;
  wire shared_pin_clock_i = shared_pin_clock_oe_n_o | shared_pin_clock_o;
  wire shared_pin_data_i = (shared_pin_data_oe_n_o | shared_pin_data_o) & !sda_pull;
  int failures = 0, cmp_count = 0, load_n = 0, cyc = 0;

  sbc_ctrl i_sbc_ctrl (.*);
  sbc_eeprom_model i_sbc_eeprom_model (.scl_i(shared_pin_clock_i), .sda_i(shared_pin_data_i),
    .absent_i(absent), .nack_word_i(nack_word), .sda_pull_o(sda_pull));

  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic csr_wr(input logic cfg, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    cfg_wr_i = cfg;
    cfg_wdata_i = d;
    mw_wr_i = !cfg;
    mw_addr_i = a;
    mw_wdata_i = d;
    @(negedge sys_clk_i);
    cfg_wr_i = 1'h0;
    mw_wr_i = 1'h0;
  endtask

  task automatic csr_rd(input logic [7:0] a, output logic [7:0] w, output logic [7:0] c);
    @(negedge sys_clk_i);
    mw_addr_i = a;
    mw_rd_i = 1'h1;
    cfg_rd_i = (a == 8'h47);
    @(negedge sys_clk_i);
    w = mw_rdata_o;
    c = cfg_rdata_o;
    mw_rd_i = 1'h0;
    cfg_rd_i = 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] w, c;
    csr_rd(a, w, c);
    chk(what, exp, w);
    if (a == 8'h47) chk({what, " header"}, exp, c);
  endtask

  task automatic wait_csr(input logic [7:0] mask, input logic [7:0] val, input int lim);
    logic [7:0] w, c;
    int n;
    n = 0;
    do begin
      csr_rd(8'h47, w, c);
      n++;
    end while ((w & mask) !== val && n < lim);
    chk("status wait", val, w & mask);
  endtask

  task automatic sw_go(input logic [7:0] sa, input logic [7:0] wa, input logic [7:0] d);
    logic [7:0] w, c;
    wait_csr(8'h30, 8'h00, 50);
    @(negedge sys_clk_i);
    sw_slave_addr_i = sa;
    sw_word_addr_i = wa;
    sw_wr_data_i = d;
    sw_launch_i = 1'h1;
    @(negedge sys_clk_i);
    sw_launch_i = 1'h0;
    csr_rd(8'h47, w, c);
    chk("sw busy", 8'h20, w & 8'h20);
    wait_csr(8'h30, 8'h00, 400);
  endtask

  always @(negedge sys_clk_i) begin
    if (load_wr_o === 1'h1) begin
      chk("load index", load_n[7:0], load_index_o);
      chk("load data", load_n[7:0] ^ 8'ha5, load_data_o);
      load_n = load_n + 1;
    end
  end

  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      failures++;
      $display("timeout");
      conclude();
    end
  end

  initial begin
    repeat (8) @(negedge sys_clk_i);
    reset_i = 1'h0;
    rd_chk(8'h47, 8'h00, "csr reset");
    csr_wr(1'h0, 8'h47, 8'hc4);
    rd_chk(8'h47, 8'h84, "csr window write");
    csr_wr(1'h1, 8'h47, 8'h04);
    rd_chk(8'h47, 8'h04, "csr header write");
    csr_wr(1'h0, 8'h46, 8'hff);
    rd_chk(8'h46, 8'h00, "unmapped read");
    rd_chk(8'h47, 8'h04, "csr after unmapped");
    chk("no load in reset", 8'h00, load_n[7:0]);
    $display("register test done");
    @(negedge sys_clk_i);
    platform_reset_n_i = 1'h1;
    wait_csr(8'h10, 8'h10, 50);
    wait_csr(8'h30, 8'h00, 2000);
    rd_chk(8'h47, 8'h0c, "after download");
    chk("load count", 8'h10, load_n[7:0]);
    gpio_data_oe_n_i = 1'h0;
    gpio_data_out_i = 1'h0;
    repeat (4) @(negedge sys_clk_i);
    chk("bus owns data pin", 8'h01, {7'h00, shared_pin_data_oe_n_o});
    gpio_data_oe_n_i = 1'h1;
    $display("download test done");
    sw_go(8'ha0, 8'h05, 8'h5a);
    chk("eeprom word 5", 8'h5a, i_sbc_eeprom_model.mem[5]);
    sw_go(8'ha1, 8'h05, 8'h00);
    chk("sw read", 8'h5a, sw_rd_data_o);
    csr_wr(1'h0, 8'h47, 8'h8c);
    sw_go(8'ha0, 8'h09, 8'h3c);
    sw_go(8'ha1, 8'h09, 8'h00);
    chk("short read", 8'h3c ^ 8'ha5, sw_rd_data_o);
    csr_wr(1'h0, 8'h47, 8'h0c);
    $display("software cycle test done");
    sw_go(8'hb0, 8'h00, 8'h00);
    repeat (20) @(negedge sys_clk_i);
    rd_chk(8'h47, 8'h0e, "sw error");
    csr_wr(1'h0, 8'h47, 8'h0c);
    rd_chk(8'h47, 8'h0e, "error kept");
    csr_wr(1'h1, 8'h47, 8'h0e);
    rd_chk(8'h47, 8'h0c, "error cleared");
    $display("error test done");
    nack_word = 1'h1;
    platform_reset_n_i = 1'h0;
    repeat (6) @(negedge sys_clk_i);
    platform_reset_n_i = 1'h1;
    wait_csr(8'h10, 8'h10, 50);
    wait_csr(8'h30, 8'h00, 2000);
    rd_chk(8'h47, 8'h0d, "load error");
    chk("no extra bytes", 8'h10, load_n[7:0]);
    csr_wr(1'h0, 8'h47, 8'h0d);
    rd_chk(8'h47, 8'h0c, "load error cleared");
    $display("load error test done");
    absent = 1'h1;
    reset_i = 1'h1;
    platform_reset_n_i = 1'h0;
    repeat (3) @(negedge sys_clk_i);
    reset_i = 1'h0;
    rd_chk(8'h47, 8'h00, "csr second reset");
    platform_reset_n_i = 1'h1;
    wait_csr(8'h10, 8'h10, 50);
    repeat (300) @(negedge sys_clk_i);
    rd_chk(8'h47, 8'h10, "slow detect");
    wait_csr(8'h30, 8'h00, 2000);
    rd_chk(8'h47, 8'h00, "no eeprom");
    chk("no bytes", 8'h10, load_n[7:0]);
    gpio_clk_out_i = 1'h0;
    gpio_clk_oe_n_i = 1'h0;
    gpio_data_out_i = 1'h1;
    gpio_data_oe_n_i = 1'h0;
    repeat (6) @(negedge sys_clk_i);
    chk("gpio drives pin", 8'h00, {7'h00, shared_pin_clock_oe_n_o});
    chk("gpio pin level", 8'h00, {7'h00, gpio_clk_in_o});
    chk("gpio clock out", 8'h00, {7'h00, shared_pin_clock_o});
    chk("gpio data out", 8'h01, {7'h00, shared_pin_data_o});
    chk("gpio data in", 8'h01, {7'h00, gpio_data_in_o});
    gpio_clk_oe_n_i = 1'h1;
    gpio_data_oe_n_i = 1'h1;
    $display("absent eeprom test done");
    conclude();
  end
endmodule
`default_nettype wire
